// >>> mcuex_pkg.sv
// Package of constants and types for the instruction execution datapath
package mcuex_pkg;

  localparam int          CLKS_PER_ICYCLE = 4;
  localparam logic [1:0]  PHASE_LAST      = 2'h3;
  localparam int          DATA_W          = 8;
  localparam int          PC_W            = 13;
  localparam int          STACK_DEPTH     = 8;
  localparam logic [7:0]  WACC_RST        = 8'h00;
  localparam logic [12:0] PC_RST          = 13'h0000;
  localparam logic [7:0]  PCLOW_ADDR      = 8'h06;
  localparam logic [7:0]  BCD_LOW_FIX     = 8'h06;
  localparam logic [7:0]  BCD_HIGH_FIX    = 8'h60;
  localparam logic [3:0]  BCD_NIBBLE_MAX  = 4'h9;

  typedef enum logic [5:0] {
    OP_NOP, OP_MOV_MA, OP_MOV_AM, OP_MOV_XA,
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_ADDX, OP_SUBX,
    OP_BCD,
    OP_AND, OP_OR, OP_XOR, OP_ANDX, OP_ORX, OP_XORX,
    OP_CPL, OP_INC, OP_DEC,
    OP_RR, OP_RL, OP_RRTC, OP_RLTC,
    OP_CLRB, OP_SETB, OP_SZ, OP_SNZB, OP_SZB, OP_SIZ, OP_SDZ,
    OP_CLR, OP_SET, OP_SWAP,
    OP_JMP, OP_CALL, OP_RET, OP_RETX, OP_TABRD
  } mcuex_op_t;

endpackage

// >>> mcuex_core.sv
// Instruction execution datapath of an 8-bit controller core
// Functional notes
// - An instruction cycle is exactly four system clocks.
// - Normal ops take one cycle; jump, call, return, table read take two.
// - Writing the program counter low byte acts as a jump, one extra cycle.
// - Skip ops take one cycle without skip, two when skipping.
// - Tests on a memory byte or bit continue or skip the next op.
// - Moves: memory to accumulator, accumulator to memory, immediate.
// - Every add and subtract form updates zero, carry, nibble and range.
// - Carry marks sums above 255; on subtract it is set when there is no borrow.
// - BCD correct adjusts accumulator into memory, changes carry only.
// - AND, OR, XOR forms change only the zero flag.
// - Logic ops always take one operand from the accumulator.
// - Invert writes back or to accumulator, zero flag only.
// - Increment and decrement by one, to memory or accumulator, zero only.
// - Plain rotates go to memory or accumulator, flags unchanged.
// - Rotates through carry form a 9-bit ring, carry flag only.
// - Bit set and clear change only the addressed bit internally.
// - Call saves return address; return resumes after the call.
// - Table read fetches program memory to data memory and high byte.
module mcuex_core #(
  parameter int STACK_DEPTH = mcuex_pkg::STACK_DEPTH
) (
  input  wire logic                   mclk_i,
  input  wire logic                   sys_rst_i,
  input  wire mcuex_pkg::mcuex_op_t   op_i,
  input  wire logic                   to_acc_i,
  input  wire logic [7:0]             mem_addr_i,
  input  wire logic [7:0]             mem_rdata_i,
  input  wire logic [7:0]             imm_i,
  input  wire logic [2:0]             bit_sel_i,
  input  wire logic [12:0]            target_i,
  input  wire logic [15:0]            table_data_i,
  output logic                        op_take_o,
  output logic [12:0]                 pc_o,
  output logic                        mem_we_o,
  output logic [7:0]                  mem_waddr_o,
  output logic [7:0]                  mem_wdata_o,
  output logic [7:0]                  working_accumulator_o,
  output logic [7:0]                  table_high_byte_o,
  output logic                        zero_flag_o,
  output logic                        carry_flag_o,
  output logic                        nibble_carry_flag_o,
  output logic                        signed_range_flag_o
);

  initial begin
    if (STACK_DEPTH < 2 || STACK_DEPTH > 256 ||
        (1 << $clog2(STACK_DEPTH)) != STACK_DEPTH) begin
      $error("STACK_DEPTH out of range");
    end
  end

  localparam int SPW = $clog2(STACK_DEPTH);

  typedef enum logic [1:0] {MCUEX_EXEC, MCUEX_EXTRA} mcuex_state_t;

  mcuex_state_t state_q;
  logic [1:0]   phase_q;
  logic [7:0]   acc_q;
  logic [12:0]  pc_q;
  logic         z_q, c_q, nc_q, sr_q;
  logic         skip_q;
  logic [7:0]   thb_q;
  logic         we_q;
  logic [7:0]   waddr_q, wdata_q;
  logic [12:0]  stack_q [STACK_DEPTH];
  logic [SPW-1:0] sp_q;
  logic         take_q;

  logic         last_phase;
  assign last_phase = (phase_q == mcuex_pkg::PHASE_LAST);

  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // Four clocks per instruction cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Combinational execute
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [7:0]  opb, res;
  logic        cin, sub_op, arith, logic_op, zflag_op, wr_mem;
  logic        do_skip, two_cyc, pclow_hit, new_c, rot_c;
  logic [7:0]  bcd;
  logic        bcd_c;

  always_comb begin
    opb      = (op_i inside {mcuex_pkg::OP_ADDX, mcuex_pkg::OP_SUBX,
               mcuex_pkg::OP_ANDX, mcuex_pkg::OP_ORX, mcuex_pkg::OP_XORX})
               ? imm_i : mem_rdata_i;
    sub_op   = op_i inside {mcuex_pkg::OP_SUB, mcuex_pkg::OP_SBC,
                            mcuex_pkg::OP_SUBX};
    arith    = op_i inside {mcuex_pkg::OP_ADD, mcuex_pkg::OP_ADC,
               mcuex_pkg::OP_SUB, mcuex_pkg::OP_SBC, mcuex_pkg::OP_ADDX,
               mcuex_pkg::OP_SUBX};
    // Carry doubles as not-borrow on subtract
    cin      = (op_i == mcuex_pkg::OP_ADC || op_i == mcuex_pkg::OP_SBC)
               ? c_q : sub_op;
    sum9     = {1'b0, acc_q} + {1'b0, sub_op ? ~opb : opb} + {8'h00, cin};
    sum5     = {1'b0, acc_q[3:0]} + {1'b0, sub_op ? ~opb[3:0] : opb[3:0]}
               + {4'h0, cin};
    bcd      = acc_q;
    bcd_c    = c_q;
    if (acc_q[3:0] > mcuex_pkg::BCD_NIBBLE_MAX || nc_q) begin
      bcd = acc_q + mcuex_pkg::BCD_LOW_FIX;
    end
    if (acc_q[7:4] > mcuex_pkg::BCD_NIBBLE_MAX || c_q) begin
      {bcd_c, bcd} = {1'b0, bcd} + {1'b0, mcuex_pkg::BCD_HIGH_FIX};
      bcd_c = 1'b1;
    end
    rot_c    = c_q;
    res      = acc_q;
    logic_op = 1'b0;
    zflag_op = 1'b0;
    wr_mem   = 1'b0;
    do_skip  = 1'b0;
    two_cyc  = 1'b0;
    unique case (op_i)
      mcuex_pkg::OP_MOV_MA: res = mem_rdata_i;
      mcuex_pkg::OP_MOV_AM: begin
        res = acc_q;
        wr_mem = 1'b1;
      end
      mcuex_pkg::OP_MOV_XA: res = imm_i;
      mcuex_pkg::OP_ADD, mcuex_pkg::OP_ADC, mcuex_pkg::OP_SUB,
      mcuex_pkg::OP_SBC: begin
        res = sum9[7:0];
        wr_mem = !to_acc_i;
      end
      mcuex_pkg::OP_ADDX, mcuex_pkg::OP_SUBX: res = sum9[7:0];
      mcuex_pkg::OP_BCD: begin
        res = bcd;
        wr_mem = 1'b1;
      end
      mcuex_pkg::OP_AND, mcuex_pkg::OP_ANDX: begin
        res = acc_q & opb;
        logic_op = 1'b1;
        wr_mem = (op_i == mcuex_pkg::OP_AND) && !to_acc_i;
      end
      mcuex_pkg::OP_OR, mcuex_pkg::OP_ORX: begin
        res = acc_q | opb;
        logic_op = 1'b1;
        wr_mem = (op_i == mcuex_pkg::OP_OR) && !to_acc_i;
      end
      mcuex_pkg::OP_XOR, mcuex_pkg::OP_XORX: begin
        res = acc_q ^ opb;
        logic_op = 1'b1;
        wr_mem = (op_i == mcuex_pkg::OP_XOR) && !to_acc_i;
      end
      mcuex_pkg::OP_CPL: begin
        res = ~mem_rdata_i;
        zflag_op = 1'b1;
        wr_mem = !to_acc_i;
      end
      mcuex_pkg::OP_INC, mcuex_pkg::OP_DEC: begin
        res = (op_i == mcuex_pkg::OP_INC) ? mem_rdata_i + 8'h01
                                          : mem_rdata_i - 8'h01;
        zflag_op = 1'b1;
        wr_mem = !to_acc_i;
      end
      mcuex_pkg::OP_RR: begin
        res = {mem_rdata_i[0], mem_rdata_i[7:1]};
        wr_mem = !to_acc_i;
      end
      mcuex_pkg::OP_RL: begin
        res = {mem_rdata_i[6:0], mem_rdata_i[7]};
        wr_mem = !to_acc_i;
      end
      mcuex_pkg::OP_RRTC: begin
        res = {c_q, mem_rdata_i[7:1]};
        rot_c = mem_rdata_i[0];
        wr_mem = !to_acc_i;
      end
      mcuex_pkg::OP_RLTC: begin
        res = {mem_rdata_i[6:0], c_q};
        rot_c = mem_rdata_i[7];
        wr_mem = !to_acc_i;
      end
      mcuex_pkg::OP_CLRB, mcuex_pkg::OP_SETB: begin
        res = mem_rdata_i;
        res[bit_sel_i] = (op_i == mcuex_pkg::OP_SETB);
        wr_mem = 1'b1;
      end
      mcuex_pkg::OP_SZ: begin
        res = mem_rdata_i;
        wr_mem = 1'b0;
        do_skip = is_zero(mem_rdata_i);
      end
      mcuex_pkg::OP_SZB: do_skip = !mem_rdata_i[bit_sel_i];
      mcuex_pkg::OP_SNZB: do_skip = mem_rdata_i[bit_sel_i];
      mcuex_pkg::OP_SIZ, mcuex_pkg::OP_SDZ: begin
        res = (op_i == mcuex_pkg::OP_SIZ) ? mem_rdata_i + 8'h01
                                          : mem_rdata_i - 8'h01;
        wr_mem = !to_acc_i;
        do_skip = is_zero(res);
      end
      mcuex_pkg::OP_CLR: begin
        res = 8'h00;
        wr_mem = 1'b1;
      end
      mcuex_pkg::OP_SET: begin
        res = 8'hFF;
        wr_mem = 1'b1;
      end
      mcuex_pkg::OP_SWAP: begin
        res = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
        wr_mem = !to_acc_i;
      end
      mcuex_pkg::OP_RETX: res = imm_i;
      mcuex_pkg::OP_TABRD: begin
        res = table_data_i[7:0];
        wr_mem = 1'b1;
      end
      default: res = acc_q;
    endcase
    // SZ with data movement keeps acc path
    if (op_i == mcuex_pkg::OP_SZ && to_acc_i) begin
      res = mem_rdata_i;
    end
    new_c   = sub_op ? sum9[8] : sum9[8];
    pclow_hit = wr_mem && (mem_addr_i == mcuex_pkg::PCLOW_ADDR);
    two_cyc = (op_i inside {mcuex_pkg::OP_JMP, mcuex_pkg::OP_CALL,
               mcuex_pkg::OP_RET, mcuex_pkg::OP_RETX, mcuex_pkg::OP_TABRD})
              || pclow_hit;
  end

  logic acc_dst;
  assign acc_dst = !wr_mem && !(op_i inside {mcuex_pkg::OP_NOP,
    mcuex_pkg::OP_SZB, mcuex_pkg::OP_SNZB, mcuex_pkg::OP_JMP,
    mcuex_pkg::OP_CALL, mcuex_pkg::OP_RET}) &&
    !(op_i == mcuex_pkg::OP_SZ && !to_acc_i);

  logic exec;
  assign exec = last_phase && (state_q == MCUEX_EXEC) && !skip_q;

  // Sequencing of instruction cycles
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q <= MCUEX_EXEC;
      skip_q  <= 1'b0;
      take_q  <= 1'b0;
    end else begin
      take_q <= (phase_q == 2'h2) && (state_q == MCUEX_EXEC) && !skip_q;
      if (last_phase) begin
        unique case (state_q)
          MCUEX_EXEC: begin
            if (skip_q) begin
              skip_q <= 1'b0;
            end else begin
              skip_q <= do_skip;
              if (two_cyc) begin
                state_q <= MCUEX_EXTRA;
              end
            end
          end
          MCUEX_EXTRA: begin
            state_q <= MCUEX_EXEC;
          end
        endcase
      end
    end
  end

  // Program counter and return stack
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pc_q <= mcuex_pkg::PC_RST;
      sp_q <= '0;
    end else if (last_phase && (skip_q || state_q == MCUEX_EXEC)) begin
      pc_q <= pc_q + 13'h0001;
      if (exec) begin
        unique case (op_i)
          mcuex_pkg::OP_JMP: pc_q <= target_i;
          mcuex_pkg::OP_CALL: begin
            stack_q[sp_q] <= pc_q + 13'h0001;
            sp_q  <= sp_q + 1'b1;
            pc_q  <= target_i;
          end
          mcuex_pkg::OP_RET, mcuex_pkg::OP_RETX: begin
            pc_q <= stack_q[sp_q - 1'b1];
            sp_q <= sp_q - 1'b1;
          end
          default: begin
            if (pclow_hit) begin
              pc_q <= {pc_q[12:8], res};
            end
          end
        endcase
      end
    end
  end

  // Accumulator, memory write and table high byte
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      acc_q   <= mcuex_pkg::WACC_RST;
      we_q    <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
      thb_q   <= 8'h00;
    end else begin
      we_q <= exec && wr_mem;
      if (exec) begin
        waddr_q <= mem_addr_i;
        wdata_q <= res;
        if (acc_dst) begin
          acc_q <= res;
        end
        if (op_i == mcuex_pkg::OP_TABRD) begin
          thb_q <= table_data_i[15:8];
        end
      end
    end
  end

  // Status flags
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      z_q  <= 1'b0;
      c_q  <= 1'b0;
      nc_q <= 1'b0;
      sr_q <= 1'b0;
    end else if (exec) begin
      if (arith) begin
        z_q  <= is_zero(sum9[7:0]);
        c_q  <= new_c;
        nc_q <= sum5[4];
        sr_q <= (acc_q[7] == (sub_op ? ~opb[7] : opb[7]))
                && (sum9[7] != acc_q[7]);
      end else if (logic_op || zflag_op) begin
        z_q <= is_zero(res);
      end else if (op_i == mcuex_pkg::OP_BCD) begin
        c_q <= bcd_c;
      end else if (op_i inside {mcuex_pkg::OP_RRTC, mcuex_pkg::OP_RLTC}) begin
        c_q <= rot_c;
      end
    end
  end

  assign op_take_o             = take_q;
  assign pc_o                  = pc_q;
  assign mem_we_o              = we_q;
  assign mem_waddr_o           = waddr_q;
  assign mem_wdata_o           = wdata_q;
  assign working_accumulator_o = acc_q;
  assign table_high_byte_o     = thb_q;
  assign zero_flag_o           = z_q;
  assign carry_flag_o          = c_q;
  assign nibble_carry_flag_o   = nc_q;
  assign signed_range_flag_o   = sr_q;

  // Checks
  sequence s_exec_two;
    exec && two_cyc;
  endsequence

  a_phase_wrap: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    last_phase |=> phase_q == 2'h0 ##3 last_phase)
    else $error("instruction cycle not four clocks");
  a_two_cycle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_exec_two |=> state_q == MCUEX_EXTRA [*4])
    else $error("two-cycle op lacks extra cycle");
  a_low_jump: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    exec && pclow_hit && !(op_i inside {mcuex_pkg::OP_JMP, mcuex_pkg::OP_CALL,
    mcuex_pkg::OP_RET, mcuex_pkg::OP_RETX}) |=> pc_q[7:0] == $past(res))
    else $error("low byte write did not jump");
  a_skip_cycle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    exec && do_skip |=> skip_q [*4] ##1 !skip_q)
    else $error("skip did not consume cycle");
  a_carry_add: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    exec && arith |=> c_q == $past(sum9[8]))
    else $error("carry mismatch");
  a_logic_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    exec && logic_op |=> z_q == ($past(res) == 8'h00)
    && c_q == $past(c_q))
    else $error("logic op flags wrong");
  a_rot_flags: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    exec && op_i inside {mcuex_pkg::OP_RR, mcuex_pkg::OP_RL}
    |=> $stable(c_q) && $stable(z_q))
    else $error("plain rotate changed flags");
  a_call_ret: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    exec && op_i == mcuex_pkg::OP_CALL |=> stack_q[sp_q - 1'b1]
    == $past(pc_q) + 13'h0001)
    else $error("return address wrong");
  a_bit_only: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    exec && op_i == mcuex_pkg::OP_SETB |=> we_q && wdata_q ==
    ($past(mem_rdata_i) | (8'h01 << $past(bit_sel_i))))
    else $error("bit set touched other bits");

endmodule

// >>> mcuex_mem_model.sv
// Data memory model on the far side of the execution core
module mcuex_mem_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] mem_addr_i,
  output logic      [7:0] mem_rdata_o,
  input  wire logic       mem_we_i,
  input  wire logic [7:0] mem_waddr_i,
  input  wire logic [7:0] mem_wdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] dmem [256];

  initial begin
    for (int k = 0; k < 256; k++) begin
      dmem[k] = 8'h00;
    end
  end

  // Operand byte for moves, logic and skip tests
  assign mem_rdata_o = dmem[mem_addr_i];

  // Whole-byte write back, bit ops included
  always @(posedge mclk_i) begin
    if (mem_we_i) begin
      dmem[mem_waddr_i] <= mem_wdata_i;
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for the instruction execution core
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 mclk_i, sys_rst_i, to_acc_i, op_take_o, mem_we_o;
  mcuex_pkg::mcuex_op_t op_i;
  logic [7:0]           mem_addr_i, mem_rdata_i, imm_i, mem_waddr_o;
  logic [7:0]           mem_wdata_o, working_accumulator_o;
  logic [7:0]           table_high_byte_o, e_acc, e_wd, e_tbh;
  logic [2:0]           bit_sel_i;
  logic [12:0]          target_i, pc_o, e_pc;
  logic [15:0]          table_data_i;
  logic                 zero_flag_o, carry_flag_o, nibble_carry_flag_o;
  logic                 signed_range_flag_o, e_z, e_c, e_nc, e_sr, e_we;
  logic                 e_jlow;
  logic [3:0]           flg;
  logic [12:0]          stk [$];
  logic [7:0]           skm [10] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00,
                                     8'h01, 8'hFF, 8'h00, 8'h01, 8'h00};
  int                   err_count = 0, cmp_count = 0, cyc = 0;
  int                   last_take = 0, e_len = 4, j;

  assign flg = {zero_flag_o, carry_flag_o, nibble_carry_flag_o,
                signed_range_flag_o};

  mcuex_core i_mcuex_core (.mclk_i, .sys_rst_i, .op_i, .to_acc_i,
    .mem_addr_i, .mem_rdata_i, .imm_i, .bit_sel_i, .target_i,
    .table_data_i, .op_take_o, .pc_o, .mem_we_o, .mem_waddr_o,
    .mem_wdata_o, .working_accumulator_o, .table_high_byte_o,
    .zero_flag_o, .carry_flag_o, .nibble_carry_flag_o,
    .signed_range_flag_o);

  mcuex_mem_model i_mcuex_mem_model (.mclk_i(mclk_i),
    .mem_addr_i(mem_addr_i), .mem_rdata_o(mem_rdata_i),
    .mem_we_i(mem_we_o), .mem_waddr_i(mem_waddr_o),
    .mem_wdata_i(mem_wdata_o));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [7:0] v, input logic to_acc);
    if (to_acc) begin
      e_acc = v;
    end else begin
      e_we = 1'b1;
      e_wd = v;
    end
  endtask

  task automatic zput(input logic [7:0] v, input logic to_acc);
    e_z = (v == 8'h00);
    put(v, to_acc);
  endtask

  task automatic model(input mcuex_pkg::mcuex_op_t op, input logic ta,
                       input logic [7:0] a, m, x, input logic [2:0] b);
    logic [7:0] o, y;
    logic [8:0] r;
    logic [4:0] h;
    logic       ci, sb, ix, sk;
    y = m;
    sk = 1'b0;
    e_we = 1'b0;
    e_jlow = 1'b0;
    e_len = 4;
    e_pc = e_pc + 13'h0001;
    sb = op inside {mcuex_pkg::OP_SUB, mcuex_pkg::OP_SBC, mcuex_pkg::OP_SUBX};
    ix = op inside {mcuex_pkg::OP_ADDX, mcuex_pkg::OP_SUBX};
    case (op)
      mcuex_pkg::OP_MOV_MA: e_acc = m;
      mcuex_pkg::OP_MOV_XA: e_acc = x;
      mcuex_pkg::OP_MOV_AM: put(e_acc, 1'b0);
      mcuex_pkg::OP_ADD, mcuex_pkg::OP_ADC, mcuex_pkg::OP_SUB,
      mcuex_pkg::OP_SBC, mcuex_pkg::OP_ADDX, mcuex_pkg::OP_SUBX: begin
        o = ix ? x : m;
        o = sb ? ~o : o;
        ci = (op inside {mcuex_pkg::OP_ADC, mcuex_pkg::OP_SBC}) ? e_c : sb;
        r = {1'b0, e_acc} + {1'b0, o} + {8'h00, ci};
        h = {1'b0, e_acc[3:0]} + {1'b0, o[3:0]} + {4'h0, ci};
        e_sr = (e_acc[7] == o[7]) && (r[7] != e_acc[7]);
        e_c = r[8];
        e_nc = h[4];
        zput(r[7:0], ta | ix);
      end
      mcuex_pkg::OP_BCD: begin
        if (e_acc[3:0] > 4'h9 || e_nc) y = e_acc + 8'h06;
        else y = e_acc;
        if (e_acc[7:4] > 4'h9 || e_c) begin
          y = y + 8'h60;
          e_c = 1'b1;
        end
        put(y, 1'b0);
      end
      mcuex_pkg::OP_AND:  zput(e_acc & m, ta);
      mcuex_pkg::OP_OR:   zput(e_acc | m, ta);
      mcuex_pkg::OP_XOR:  zput(e_acc ^ m, ta);
      mcuex_pkg::OP_ANDX: zput(e_acc & x, 1'b1);
      mcuex_pkg::OP_ORX:  zput(e_acc | x, 1'b1);
      mcuex_pkg::OP_XORX: zput(e_acc ^ x, 1'b1);
      mcuex_pkg::OP_CPL:  zput(~m, ta);
      mcuex_pkg::OP_INC:  zput(m + 8'h01, ta);
      mcuex_pkg::OP_DEC:  zput(m - 8'h01, ta);
      mcuex_pkg::OP_RR:   put({m[0], m[7:1]}, ta);
      mcuex_pkg::OP_RL:   put({m[6:0], m[7]}, ta);
      mcuex_pkg::OP_RRTC, mcuex_pkg::OP_RLTC: begin
        if (op == mcuex_pkg::OP_RRTC) put({e_c, m[7:1]}, ta);
        else put({m[6:0], e_c}, ta);
        e_c = (op == mcuex_pkg::OP_RRTC) ? m[0] : m[7];
      end
      mcuex_pkg::OP_CLRB, mcuex_pkg::OP_SETB: begin
        y[b] = (op == mcuex_pkg::OP_SETB);
        put(y, 1'b0);
      end
      mcuex_pkg::OP_CLR:  put(8'h00, 1'b0);
      mcuex_pkg::OP_SET:  put(8'hFF, 1'b0);
      mcuex_pkg::OP_SWAP: put({m[3:0], m[7:4]}, ta);
      mcuex_pkg::OP_SZ:   sk = (m == 8'h00);
      mcuex_pkg::OP_SZB:  sk = !m[b];
      mcuex_pkg::OP_SNZB: sk = m[b];
      mcuex_pkg::OP_SIZ, mcuex_pkg::OP_SDZ: begin
        y = (op == mcuex_pkg::OP_SIZ) ? m + 8'h01 : m - 8'h01;
        put(y, ta);
        sk = (y == 8'h00);
      end
      mcuex_pkg::OP_JMP, mcuex_pkg::OP_CALL: begin
        if (op == mcuex_pkg::OP_CALL) stk.push_back(e_pc);
        e_pc = target_i;
        e_len = 8;
      end
      mcuex_pkg::OP_RET, mcuex_pkg::OP_RETX: begin
        e_pc = stk.pop_back();
        e_len = 8;
        if (op == mcuex_pkg::OP_RETX) e_acc = x;
      end
      mcuex_pkg::OP_TABRD: begin
        put(table_data_i[7:0], 1'b0);
        e_tbh = table_data_i[15:8];
        e_len = 8;
      end
      default: e_len = 4;
    endcase
    if (sk) begin
      e_len = 8;
      e_pc = e_pc + 13'h0001;
    end
    if (e_we && a == mcuex_pkg::PCLOW_ADDR) begin
      e_pc = {e_pc[12:8], e_wd};
      e_len = 8;
      e_jlow = 1'b1;
    end
  endtask

  task automatic do_op(input mcuex_pkg::mcuex_op_t op, input logic ta,
                       input logic [7:0] a, m, x, input logic [2:0] b);
    int n;
    n = 0;
    i_mcuex_mem_model.dmem[a] = m;
    op_i = op;
    to_acc_i = ta;
    mem_addr_i = a;
    imm_i = x;
    bit_sel_i = b;
    while (op_take_o !== 1'b1 && n < 40) begin
      @(posedge mclk_i);
      #2;
      n++;
    end
    @(posedge mclk_i);
    #2;
    if (last_take != 0) check(16'(cyc - last_take), 16'(e_len));
    last_take = cyc;
    model(op, ta, a, m, x, b);
    check({8'h00, working_accumulator_o}, {8'h00, e_acc});
    check({12'h000, flg}, {12'h000, e_z, e_c, e_nc, e_sr});
    check({8'h00, table_high_byte_o}, {8'h00, e_tbh});
    if (!e_jlow) begin
      check({15'h0000, mem_we_o}, {15'h0000, e_we});
      if (e_we) check({mem_waddr_o, mem_wdata_o}, {a, e_wd});
    end
    if (e_len == 4) check({3'h0, pc_o}, {3'h0, e_pc});
  endtask

  task automatic rnd_op(input int k);
    logic [7:0] m;
    logic       ta;
    m = 8'($urandom);
    ta = (k == 26) ? 1'b0 : 1'($urandom);
    if ($urandom_range(3) == 0) m = $urandom_range(1) ? 8'hFF : 8'h00;
    do_op(mcuex_pkg::mcuex_op_t'(k), ta, 8'($urandom_range(32, 127)), m,
          8'($urandom), 3'($urandom));
  endtask

  initial begin
    void'($urandom(32'hAF6A86D2));
    {op_i, to_acc_i, mem_addr_i, imm_i, bit_sel_i} = '0;
    {target_i, table_data_i, e_acc, e_wd, e_tbh, e_pc} = '0;
    {e_z, e_c, e_nc, e_sr, e_we, e_jlow} = '0;
    sys_rst_i = 1'b1;
    repeat (10) @(posedge mclk_i);
    #2;
    sys_rst_i = 1'b0;
    check({3'h0, pc_o}, 16'h0000);
    check({4'h0, flg, working_accumulator_o}, 16'h0000);
    do_op(mcuex_pkg::OP_MOV_XA, 1'b1, 8'h20, 8'h00, 8'h38, 3'h0);
    do_op(mcuex_pkg::OP_ADD, 1'b1, 8'h21, 8'h45, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_BCD, 1'b0, 8'h22, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_MOV_XA, 1'b1, 8'h20, 8'h00, 8'h91, 3'h0);
    do_op(mcuex_pkg::OP_ADD, 1'b1, 8'h21, 8'h20, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_BCD, 1'b0, 8'h22, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_ADDX, 1'b1, 8'h23, 8'h00, 8'hEE, 3'h0);
    do_op(mcuex_pkg::OP_SUB, 1'b0, 8'h24, 8'h01, 8'h00, 3'h0);
    for (int k = 0; k < 8; k++) begin
      do_op(mcuex_pkg::OP_SETB, 1'b0, 8'h30, 8'h00, 8'h00, 3'(k));
      do_op(mcuex_pkg::OP_CLRB, 1'b0, 8'h31, 8'hFF, 8'h00, 3'(k));
    end
    for (int k = 0; k < 10; k++) begin
      do_op(mcuex_pkg::mcuex_op_t'(26 + k / 2), 1'b0, 8'h40, skm[k], 8'h00,
            3'h0);
    end
    target_i = 13'h0100;
    do_op(mcuex_pkg::OP_JMP, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_NOP, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    target_i = 13'h0200;
    do_op(mcuex_pkg::OP_CALL, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_NOP, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_RET, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_NOP, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_CALL, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_RETX, 1'b0, 8'h20, 8'h00, 8'h5A, 3'h0);
    table_data_i = 16'($urandom);
    do_op(mcuex_pkg::OP_TABRD, 1'b0, 8'h50, 8'h00, 8'h00, 3'h0);
    do_op(mcuex_pkg::OP_MOV_XA, 1'b1, 8'h20, 8'h00, 8'h40, 3'h0);
    do_op(mcuex_pkg::OP_MOV_AM, 1'b0, mcuex_pkg::PCLOW_ADDR, 8'h00, 8'h00,
          3'h0);
    do_op(mcuex_pkg::OP_NOP, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    for (int k = 0; k < 34; k++) begin
      if (k != 10) rnd_op(k);
    end
    for (int k = 0; k < 150; k++) begin
      j = $urandom_range(33);
      rnd_op((j == 10) ? 0 : j);
    end
    do_op(mcuex_pkg::OP_NOP, 1'b0, 8'h20, 8'h00, 8'h00, 3'h0);
    give_verdict();
  end
endmodule
